/* File: logic/id_measure_timer.sv */
// times one resistor measurement while the trigger level stands
`timescale 1ns/1ps
`include "ulpi_vendor_defines.svh"
module id_measure_timer #(
    parameter int CYCLES = `MEASURE_CYCLES
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // control
    input  wire logic run,
    output logic      done
);
    import ulpi_vendor_pkg::*;

    typedef struct packed {
        meas_state_t                 state;
        logic [`MEASURE_COUNT_W-1:0] count;
        logic                        done;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        unique case (s.state)
            MEAS_IDLE: begin
                next_s.count = '0;
                if (run) begin
                    next_s.state = MEAS_BUSY;
                end
            end
            MEAS_BUSY: begin
                if (!run) begin
                    next_s.state = MEAS_IDLE;
                end else if (s.count == `MEASURE_COUNT_W'(CYCLES - 1)) begin
                    next_s.done  = 1'b1;
                    next_s.state = MEAS_HOLD;
                end else begin
                    next_s.count = s.count + `MEASURE_COUNT_W'(1);
                end
            end
            MEAS_HOLD: begin
                // wait for the trigger to drop so one measurement gives one done
                if (!run) begin
                    next_s.state = MEAS_IDLE;
                end
            end
            default: begin
                next_s.state = MEAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

    a_done_on_count: assert property (@(posedge sys_clk) disable iff (rst)
        s.state == MEAS_BUSY && run && s.count == `MEASURE_COUNT_W'(CYCLES - 1) |=> done)
        else $error("measurement did not finish at full count");
    a_no_early_done: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(done) |-> $past(s.count) == `MEASURE_COUNT_W'(CYCLES - 1))
        else $error("measurement finished early");
endmodule : id_measure_timer

/* File: logic/level_edge_detect.sv */
// rise and fall pulses of a synchronous level, suppressed in the first cycle after reset
`timescale 1ns/1ps
module level_edge_detect (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // level in, pulses out
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic primed;
        logic prev;
        logic rise;
        logic fall;
    } edge_state_t;

    edge_state_t s;
    edge_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.primed = 1'b1;
        next_s.prev   = level;
        next_s.rise   = s.primed & level & ~s.prev;
        next_s.fall   = s.primed & ~level & s.prev;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = s.rise;
    assign fall = s.fall;
endmodule : level_edge_detect

/* File: logic/ulpi_vendor_defines.svh */
// register offsets, field positions, reset values and timing counts of the vendor id block
//
// How it works
// - id open flag sets on float rise while the rise enable is on
// - id open flag sets on float fall while the fall enable is on
// - latch register is read only; its flags clear once it is read
// - kit detect and kit dplus flag positions always read zero
// - measure flag bit 3 sets when finished rises with irq enabled
// - vendor registers 30h to 3Fh served by immediate register accesses
// - bits 6:5 of 31h choose hs transmit amplitude boost
// - headset audio mode on only while key 33h[3:0] equals 1010
// - three bit resistance code reports the measured id resistor
// - finished status asserts by itself when a 282 us measurement ends
// - finished status clears when the code is read at 36h to 38h
// - reading the code through the status register clears nothing
// - a one written or set into bit 4 starts a measurement
// - the trigger bit clears itself once the measurement completes
// - with irq enabled, finished rising raises the alternate interrupt
// - effective measure irq enable is the or of both enable bits
// - 36h to 38h read; 36h loads, 37h sets, 38h clears
`ifndef ULPI_VENDOR_DEFINES_SVH
`define ULPI_VENDOR_DEFINES_SVH

// register addresses
`define ADDR_ID_EVENT_LATCH   6'h21
`define ADDR_VENDOR_FIRST     6'h30
`define ADDR_VENDOR_LAST      6'h3f
`define ADDR_HS_TX_AMPLITUDE  6'h31
`define ADDR_HEADSET_KEY      6'h33
`define ADDR_MEASURE_LOAD     6'h36
`define ADDR_MEASURE_SET      6'h37
`define ADDR_MEASURE_CLEAR    6'h38

// field positions
`define BIT_OPEN_FLAG         0
`define BIT_MEAS_FLAG         3
`define BIT_BOOST_LO          5
`define BIT_TRIGGER           4
`define BIT_FINISHED          3
`define BIT_IRQ_EN            6

// reset values and keys
`define RESET_BOOST           2'h0
`define RESET_KEY             4'h0
`define RESET_CODE            3'h0
`define HEADSET_KEY_VALUE     4'ha

// timing
`define CLK_PERIOD_NS         40
`define MEASURE_TIME_NS       282000
`define MEASURE_CYCLES        ((`MEASURE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEASURE_COUNT_W       13

`endif

/* File: logic/ulpi_vendor_id_detect_regs.sv */
// carkit latch and vendor register bank: id float events, tx boost, headset key, id measurement
`timescale 1ns/1ps
`include "ulpi_vendor_defines.svh"
module ulpi_vendor_id_detect_regs #(
    parameter int MEASURE_CYCLES = `MEASURE_CYCLES
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // immediate register access from the ulpi command decoder
    input  wire logic [5:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    output logic                            reg_rvalid,
    // enables held in the carkit interrupt enable register
    input  wire logic                       id_open_rise_enable,
    input  wire logic                       id_open_fall_enable,
    input  wire logic                       kit_measure_irq_enable,
    // id pin and resistor converter
    input  wire logic                       id_floating,
    input  wire ulpi_vendor_pkg::rid_code_t id_adc_code,
    output logic                            id_measure_trigger,
    // status copies for the carkit interrupt status register
    output logic                            id_measure_finished,
    output ulpi_vendor_pkg::rid_code_t      id_resistance_code,
    // analog and rxcmd controls
    output ulpi_vendor_pkg::boost_t         hs_tx_amplitude,
    output logic                            headset_audio_active,
    output logic                            alt_int
);
    import ulpi_vendor_pkg::*;

    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic in_vendor_range(input logic [5:0] addr);
        in_vendor_range = (addr >= `ADDR_VENDOR_FIRST) && (addr <= `ADDR_VENDOR_LAST);
    endfunction : in_vendor_range

    function automatic logic is_measure_addr(input logic [5:0] addr);
        is_measure_addr = (addr >= `ADDR_MEASURE_LOAD) && (addr <= `ADDR_MEASURE_CLEAR);
    endfunction : is_measure_addr

    function automatic logic [7:0] apply_write(input logic [7:0] old, input logic [7:0] data,
                                               input wr_kind_t kind);
        unique case (kind)
            WR_LOAD:  apply_write = data;
            WR_SET:   apply_write = old | data;
            WR_CLEAR: apply_write = old & ~data;
            default:  apply_write = old;
        endcase
    endfunction : apply_write

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        boost_t     boost;
        logic [3:0] key;
        logic       headset_on;
        rid_code_t  code;
        logic       finished;
        logic       trigger;
        logic       irq_en;
        logic       open_flag;
        logic       meas_flag;
        logic       alt_int;
        logic [7:0] rdata;
        logic       rvalid;
    } regs_state_t;

    regs_state_t s;
    regs_state_t next_s;

    logic       float_rise;
    logic       float_fall;
    logic       meas_done;
    logic       meas_event;
    logic       irq_en_eff;
    logic       open_event;
    logic       rd_latch;
    logic       rd_measure;
    logic       wr_vendor;
    logic [7:0] measure_word;
    logic [7:0] measure_next;
    wr_kind_t   measure_kind;

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    level_edge_detect u_float_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (id_floating),
        .rise    (float_rise),
        .fall    (float_fall)
    );

    id_measure_timer #(
        .CYCLES (MEASURE_CYCLES)
    ) u_measure_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (s.trigger),
        .done    (meas_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decode and events

    assign irq_en_eff = s.irq_en | kit_measure_irq_enable;
    // only a rise of finished is an event; a repeat while it stands is not
    assign meas_event = meas_done & ~s.finished;
    assign open_event = (float_rise & id_open_rise_enable)
                      | (float_fall & id_open_fall_enable);
    assign rd_latch   = reg_rd && (reg_addr == `ADDR_ID_EVENT_LATCH);
    assign rd_measure = reg_rd && is_measure_addr(reg_addr);
    assign wr_vendor  = reg_wr && in_vendor_range(reg_addr);

    // bit 5 is reserved and left at zero here, as the link keeps it
    assign measure_word = {1'b0, s.irq_en, 1'b0, s.trigger, s.finished, s.code};

    always_comb begin
        measure_kind = WR_LOAD;
        if (reg_addr == `ADDR_MEASURE_SET) begin
            measure_kind = WR_SET;
        end else if (reg_addr == `ADDR_MEASURE_CLEAR) begin
            measure_kind = WR_CLEAR;
        end
    end

    assign measure_next = apply_write(measure_word, reg_wdata, measure_kind);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s         = s;
        next_s.alt_int = 1'b0;
        next_s.rvalid  = 1'b0;

        // software writes
        if (wr_vendor) begin
            if (reg_addr == `ADDR_HS_TX_AMPLITUDE) begin
                next_s.boost = boost_t'(reg_wdata[`BIT_BOOST_LO+1:`BIT_BOOST_LO]);
            end
            if (reg_addr == `ADDR_HEADSET_KEY) begin
                next_s.key = reg_wdata[3:0];
            end
            if (is_measure_addr(reg_addr)) begin
                next_s.code    = rid_code_t'(measure_next[2:0]);
                next_s.trigger = measure_next[`BIT_TRIGGER];
                next_s.irq_en  = measure_next[`BIT_IRQ_EN];
            end
        end

        // reads: returned value is taken before any auto clear
        if (reg_rd) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = 8'h00;
            if (reg_addr == `ADDR_ID_EVENT_LATCH) begin
                next_s.rdata[`BIT_OPEN_FLAG] = s.open_flag;
                next_s.rdata[`BIT_MEAS_FLAG] = s.meas_flag;
                next_s.rdata[2:1]            = 2'b00;
            end else if (reg_addr == `ADDR_HS_TX_AMPLITUDE) begin
                next_s.rdata[`BIT_BOOST_LO+1:`BIT_BOOST_LO] = s.boost;
            end else if (reg_addr == `ADDR_HEADSET_KEY) begin
                next_s.rdata[3:0] = s.key;
            end else if (is_measure_addr(reg_addr)) begin
                next_s.rdata = measure_word;
            end
        end
        if (rd_latch) begin
            next_s.open_flag = 1'b0;
            next_s.meas_flag = 1'b0;
        end
        if (rd_measure) begin
            next_s.finished = 1'b0;
        end

        // hardware events win over the software clears above
        if (meas_done) begin
            next_s.trigger  = 1'b0;
            next_s.finished = 1'b1;
            next_s.code     = id_adc_code;
        end
        if (open_event) begin
            next_s.open_flag = 1'b1;
        end
        if (meas_event && irq_en_eff) begin
            next_s.meas_flag = 1'b1;
        end
        next_s.alt_int    = (meas_event & irq_en_eff) | open_event;
        next_s.headset_on = (next_s.key == `HEADSET_KEY_VALUE);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s       <= '0;
            s.boost <= boost_t'(`RESET_BOOST);
            s.key   <= `RESET_KEY;
            s.code  <= rid_code_t'(`RESET_CODE);
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // the status copies only follow state; reads at the status register never touch them
    assign id_measure_finished  = s.finished;
    assign id_resistance_code   = s.code;
    assign id_measure_trigger   = s.trigger;
    assign hs_tx_amplitude          = s.boost;
    assign headset_audio_active = s.headset_on;
    assign alt_int              = s.alt_int;
    assign reg_rdata            = s.rdata;
    assign reg_rvalid           = s.rvalid;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_open_rise_sets: assert property (@(posedge sys_clk) disable iff (rst)
        float_rise && id_open_rise_enable |=> s.open_flag)
        else $error("open flag missed a float rise");
    a_open_fall_sets: assert property (@(posedge sys_clk) disable iff (rst)
        float_fall && id_open_fall_enable |=> s.open_flag && alt_int)
        else $error("open flag missed a float fall");
    a_latch_read_clears: assert property (@(posedge sys_clk) disable iff (rst)
        rd_latch && !open_event && !meas_event |=> !s.open_flag && !s.meas_flag)
        else $error("latch flags survived a read");
    a_latch_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
        rd_latch |=> reg_rvalid && reg_rdata[2:1] == 2'b00 && reg_rdata[7:4] == 4'h0)
        else $error("unimplemented latch bits read nonzero");
    a_meas_flag_sets: assert property (@(posedge sys_clk) disable iff (rst)
        meas_event && irq_en_eff |=> s.meas_flag)
        else $error("measure flag missed a finish");
    a_boost_follows: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `ADDR_HS_TX_AMPLITUDE |=> hs_tx_amplitude == $past(reg_wdata[6:5]))
        else $error("boost field not written");
    a_headset_key: assert property (@(posedge sys_clk) disable iff (rst)
        headset_audio_active == (s.key == `HEADSET_KEY_VALUE))
        else $error("headset mode disagrees with key");
    a_code_captured: assert property (@(posedge sys_clk) disable iff (rst)
        meas_done |=> id_resistance_code == $past(id_adc_code))
        else $error("resistance code not captured");
    a_finished_read_clr: assert property (@(posedge sys_clk) disable iff (rst)
        rd_measure && !meas_done |=> !id_measure_finished)
        else $error("finished status survived a code read");
    a_trigger_starts: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && (reg_addr == `ADDR_MEASURE_LOAD || reg_addr == `ADDR_MEASURE_SET)
        && reg_wdata[4] && !meas_done |=> id_measure_trigger)
        else $error("trigger bit not taken");
    a_trigger_self_clr: assert property (@(posedge sys_clk) disable iff (rst)
        meas_done |=> !id_measure_trigger && id_measure_finished)
        else $error("trigger did not clear after measurement");
    a_alt_int_measure: assert property (@(posedge sys_clk) disable iff (rst)
        meas_event && (s.irq_en || kit_measure_irq_enable) |=> alt_int ##1 !alt_int)
        else $error("alternate interrupt missing after finish");
    a_clear_addr_bits: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `ADDR_MEASURE_CLEAR && !meas_done
        |=> s.irq_en == ($past(s.irq_en) & ~$past(reg_wdata[6])))
        else $error("clear address misbehaved");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == `ADDR_HEADSET_KEY |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    // bus answers
    a_rvalid_follows: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("rvalid late");
    a_rdata_holds: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");
    a_measure_readback: assert property (
        rd_measure |=> reg_rdata == $past(measure_word))
        else $error("measure readback wrong");
    a_boost_reserved: assert property (
        reg_rd && reg_addr == `ADDR_HS_TX_AMPLITUDE
        |=> reg_rdata[4:0] == 5'h00 && !reg_rdata[7])
        else $error("boost reserved set");
    a_unused_vendor: assert property (
        reg_rd && reg_addr == `ADDR_VENDOR_FIRST
        |=> reg_rdata == 8'h00)
        else $error("unused vendor nonzero");

    // latch flags and interrupt
    a_open_needs_event: assert property (
        !s.open_flag && !open_event |=> !s.open_flag)
        else $error("open flag unprompted");
    a_meas_needs_event: assert property (
        !s.meas_flag && !(meas_event && irq_en_eff)
        |=> !s.meas_flag)
        else $error("measure flag unprompted");
    a_set_beats_read: assert property (
        rd_latch && open_event |=> s.open_flag)
        else $error("read beat an event");
    a_alt_int_cause: assert property (
        !open_event && !(meas_event && irq_en_eff)
        |=> !alt_int)
        else $error("alt_int unprompted");

    // measurement control and headset key
    a_finished_by_hw: assert property (
        !s.finished && !meas_done |=> !s.finished)
        else $error("finished unprompted");
    a_other_read_keeps: assert property (
        s.finished && !rd_measure |=> s.finished)
        else $error("finished lost");
    a_set_addr_ors: assert property (
        reg_wr && reg_addr == `ADDR_MEASURE_SET && !meas_done
        |=> s.irq_en == ($past(s.irq_en) | $past(reg_wdata[6])))
        else $error("set address wrong");
    a_load_addr: assert property (
        reg_wr && reg_addr == `ADDR_MEASURE_LOAD && !meas_done
        |=> s.irq_en == $past(reg_wdata[6]) && s.trigger == $past(reg_wdata[4]))
        else $error("load address wrong");
    a_clear_aborts: assert property (
        reg_wr && reg_addr == `ADDR_MEASURE_CLEAR && reg_wdata[4]
        |=> !id_measure_trigger)
        else $error("clear kept trigger");
    a_key_written: assert property (
        reg_wr && reg_addr == `ADDR_HEADSET_KEY
        |=> s.key == $past(reg_wdata[3:0]))
        else $error("key not written");

    c_measure_done: cover property (@(posedge sys_clk) disable iff (rst)
        meas_done ##1 alt_int);
    c_open_change: cover property (@(posedge sys_clk) disable iff (rst)
        open_event ##[1:20] rd_latch);
    c_headset_on: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(headset_audio_active));
    c_read_meets_set: cover property (@(posedge sys_clk) disable iff (rst)
        rd_latch && open_event);
endmodule : ulpi_vendor_id_detect_regs

/* File: logic/ulpi_vendor_pkg.sv */
// types shared by the vendor id register block
package ulpi_vendor_pkg;
    typedef enum logic [1:0] {
        BOOST_NOMINAL = 2'b00,
        BOOST_11P1    = 2'b01,
        BOOST_7P4     = 2'b10,
        BOOST_3P7     = 2'b11
    } boost_t;

    typedef enum logic [2:0] {
        RID_0_OHM   = 3'b000,
        RID_75_OHM  = 3'b001,
        RID_100K    = 3'b010,
        RID_200K    = 3'b011,
        RID_440K    = 3'b100,
        RID_FLOAT   = 3'b101,
        RID_SPARE   = 3'b110,
        RID_ERROR   = 3'b111
    } rid_code_t;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b00,
        MEAS_BUSY = 2'b01,
        MEAS_HOLD = 2'b10
    } meas_state_t;

    typedef enum logic [1:0] {
        WR_LOAD  = 2'b00,
        WR_SET   = 2'b01,
        WR_CLEAR = 2'b10
    } wr_kind_t;
endpackage : ulpi_vendor_pkg

/* File: sim/link_model.sv */
// link controller model issuing immediate register writes and reads
`timescale 1ns/1ps
module link_model (
    // clock
    input  wire logic       sys_clk,
    // register strobes toward the block
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // a released bus shows the inverse of its last value; a read releases only the address and leaves the write data as it stands
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = (a inside {6'h36, 6'h37, 6'h38}) ? (d & 8'hdf) : d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
        reg_addr = ~reg_addr;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
    endtask : rd
endmodule : link_model

/* File: sim/tb.sv */
// self-checking bench of the vendor id register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
    import ulpi_vendor_pkg::*;
    localparam int MC = 20;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       rise_en = 1'b0;
    logic       fall_en = 1'b0;
    logic       kit_en = 1'b0;
    logic       id_floating = 1'b0;
    rid_code_t  id_adc_code = RID_0_OHM;
    logic       id_measure_trigger;
    logic       id_measure_finished;
    rid_code_t  id_resistance_code;
    boost_t     hs_tx_amplitude;
    logic       headset_audio_active;
    logic       alt_int;
    int         n_errors = 0;
    int         num_checks = 0;
    int         n_alt = 0;
    int         cyc = 0;
    logic [7:0] exp_q[$];
    string      nm_q[$];
    logic [7:0] e_v;
    string      n_v;
    rid_code_t  code;
    logic [7:0] r;

    always #20 sys_clk = ~sys_clk;

    link_model link_model_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    ulpi_vendor_id_detect_regs #(.MEASURE_CYCLES(MC)) ulpi_vendor_id_detect_regs_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .id_open_rise_enable(rise_en),
        .id_open_fall_enable(fall_en), .kit_measure_irq_enable(kit_en), .id_floating(id_floating),
        .id_adc_code(id_adc_code), .id_measure_trigger(id_measure_trigger),
        .id_measure_finished(id_measure_finished), .id_resistance_code(id_resistance_code),
        .hs_tx_amplitude(hs_tx_amplitude), .headset_audio_active(headset_audio_active), .alt_int(alt_int));

    ////////////////////////////////////////////////////////////////////////////////
    // watcher: each read answer is held against the oldest note
    always @(posedge sys_clk) begin
        cyc++;
        if (alt_int === 1'b1) n_alt++;
        if (reg_rvalid === 1'b1) begin
            e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            n_v = (nm_q.size() > 0) ? nm_q.pop_front() : "unexpected_read";
            `CHK(n_v, e_v, reg_rdata)
        end
        if (cyc == 4000) begin
            n_errors++;
            $display("MISMATCH timeout exp done got hang");
            finish_test();
        end
    end

    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        link_model_inst.rd(a);
    endtask : rd

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic float_to(input logic lvl);
        step(1);
        id_floating = lvl;
        step(4);
    endtask : float_to

    // one measurement: start it, wait for the finish and check its results
    task automatic measure(input logic [5:0] a, input logic [7:0] d, input int irq);
        int k;
        int a0;
        code = rid_code_t'($urandom_range(7));
        id_adc_code = code;
        a0 = n_alt;
        link_model_inst.wr(a, d);
        `CHK("trigger_on", 1'b1, id_measure_trigger)
        k = 0;
        while (id_measure_finished !== 1'b1 && k < 4 * MC) begin
            step(1);
            k++;
        end
        `CHK("finish_time", 1'b1, (k >= MC && k <= MC + 2))
        `CHK("trigger_off", 1'b0, id_measure_trigger)
        `CHK("code", code, id_resistance_code)
        step(3);
        `CHK("alt_count", a0 + irq, n_alt)
        `CHK("finished_kept", 1'b1, id_measure_finished)
    endtask : measure

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'heefb4a0c));
        step(8);
        rst = 1'b0;
        rd(6'h21, 8'h00, "latch_reset");
        rd(6'h31, 8'h00, "boost_reset");
        rd(6'h33, 8'h00, "key_reset");
        rd(6'h36, 8'h00, "measure_reset");
        rd(6'h3f, 8'h00, "unused_vendor");
        link_model_inst.wr(6'h21, 8'hff);
        link_model_inst.wr(6'h30, 8'hff);
        rd(6'h21, 8'h00, "latch_readonly");
        rd(6'h30, 8'h00, "unused_write");
        $display("test reset_and_map done");
        for (int v = 0; v < 4; v++) begin
            r = $urandom();
            link_model_inst.wr(6'h31, {r[7], v[1:0], r[4:0]});
            step(1);
            `CHK("boost_out", boost_t'(v[1:0]), hs_tx_amplitude)
            rd(6'h31, {1'b0, v[1:0], 5'h00}, "boost_read");
        end
        link_model_inst.wr(6'h33, 8'hfa);
        step(1);
        `CHK("headset_on", 1'b1, headset_audio_active)
        rd(6'h33, 8'h0a, "key_read");
        link_model_inst.wr(6'h33, 8'h5b);
        step(1);
        `CHK("headset_off", 1'b0, headset_audio_active)
        $display("test boost_and_key done");
        rise_en = 1'b1;
        float_to(1'b1);
        `CHK("float_alt", 1, n_alt)
        rd(6'h21, 8'h01, "open_rise");
        rd(6'h21, 8'h00, "open_cleared");
        float_to(1'b0);
        rd(6'h21, 8'h00, "fall_disabled");
        rise_en = 1'b0;
        fall_en = 1'b1;
        float_to(1'b1);
        rd(6'h21, 8'h00, "rise_disabled");
        float_to(1'b0);
        rd(6'h21, 8'h01, "open_fall");
        fall_en = 1'b0;
        $display("test id_float done");
        measure(6'h37, 8'h50, 1);
        rd(6'h21, 8'h08, "meas_flag");
        rd(6'h36, {5'h09, code}, "meas_read");
        rd(6'h37, {5'h08, code}, "finished_cleared");
        step(1);
        `CHK("finished_out", 1'b0, id_measure_finished)
        link_model_inst.wr(6'h38, 8'h40);
        rd(6'h38, {5'h00, code}, "clear_addr");
        kit_en = 1'b1;
        measure(6'h36, 8'h30, 1);
        rd(6'h21, 8'h08, "kit_enable_flag");
        rd(6'h36, {5'h01, code}, "load_read");
        kit_en = 1'b0;
        measure(6'h36, 8'h10, 0);
        rd(6'h21, 8'h00, "no_irq_flag");
        rd(6'h38, {5'h01, code}, "no_irq_read");
        $display("test measure done");
        step(4);
        `CHK("queue_empty", 0, exp_q.size())
        finish_test();
    end
endmodule : tb
